// ---- smcc_pkg.sv ----
// Constants shared by the sensor mode and command controller
package smcc_pkg;

	// ==========================================================================
	// Bus addresses and general call
	localparam logic [6:0]  SMCC_OWN_ADDR       = 7'h25;
	localparam logic [6:0]  SMCC_GC_ADDR        = 7'h00;
	localparam logic [7:0]  SMCC_GC_RESET       = 8'h06;

	// ==========================================================================
	// Command codes
	localparam logic [15:0] SMCC_CMD_STOP       = 16'h3ff9;
	localparam logic [15:0] SMCC_CMD_TRIG_MF    = 16'h3624;
	localparam logic [15:0] SMCC_CMD_TRIG_DP    = 16'h362f;
	localparam logic [15:0] SMCC_CMD_TRIG_MF_CS = 16'h3726;
	localparam logic [15:0] SMCC_CMD_TRIG_DP_CS = 16'h372d;
	localparam logic [15:0] SMCC_CMD_SLEEP      = 16'h3677;
	localparam logic [15:0] SMCC_CMD_CONT_MF_AV = 16'h3603;
	localparam logic [15:0] SMCC_CMD_CONT_MF    = 16'h3608;
	localparam logic [15:0] SMCC_CMD_CONT_DP_AV = 16'h3615;
	localparam logic [15:0] SMCC_CMD_CONT_DP    = 16'h361e;

	// ==========================================================================
	// Checksum and framing
	localparam logic [7:0]  SMCC_CRC_POLY       = 8'h31;
	localparam logic [7:0]  SMCC_CRC_INIT       = 8'hff;
	localparam logic [3:0]  SMCC_ACK_BIT        = 4'h8;
	localparam logic [3:0]  SMCC_LAST_BYTE      = 4'h8;
	localparam logic [1:0]  SMCC_CMD_BYTES      = 2'h2;

	// ==========================================================================
	// Timing
	localparam int SMCC_SYS_CLK_HZ     = 40_000_000;
	localparam int SMCC_MEAS_TIME_MS   = 45;
	localparam int SMCC_RESET_TIME_MS  = 2;
	localparam int SMCC_CONT_FIRST_MS  = 8;
	localparam int SMCC_CONT_PERIOD_US = 500;
	localparam int SMCC_MEAS_CYC   = SMCC_MEAS_TIME_MS * (SMCC_SYS_CLK_HZ / 1000);
	localparam int SMCC_RESET_CYC  = SMCC_RESET_TIME_MS * (SMCC_SYS_CLK_HZ / 1000);
	localparam int SMCC_CONT_FIRST_CYC  = SMCC_CONT_FIRST_MS * (SMCC_SYS_CLK_HZ / 1000);
	localparam int SMCC_CONT_PERIOD_CYC = SMCC_CONT_PERIOD_US * (SMCC_SYS_CLK_HZ / 1000000);
	localparam int SMCC_CNT_W = 21;

	typedef logic [SMCC_CNT_W-1:0] smcc_cnt_t;

	typedef enum logic [2:0] {
		SMCC_BUS_IDLE,
		SMCC_BUS_ADDR,
		SMCC_BUS_WRITE,
		SMCC_BUS_READ,
		SMCC_BUS_SKIP
	} smcc_bus_t;

	typedef enum logic [1:0] {
		SMCC_MODE_IDLE,
		SMCC_MODE_TRIG,
		SMCC_MODE_CONT,
		SMCC_MODE_SLEEP
	} smcc_mode_t;

endpackage

// ---- smcc_core.sv ----
// Sensor mode and command controller behind a two-wire bus target
// Overview of operation
// - Stop code 0x3FF9 ends continuous mode, heater off, back to idle.
// - Continuous mode ignores every command except stop and general-call reset.
// - Each trigger command yields exactly one pressure and temperature result.
// - 0x3624 / 0x362F trigger at once without stretching, flow / pressure compensation.
// - 0x3726 / 0x372D trigger with clock stretching, flow / pressure compensation.
// - Stretch trigger: read header acked, clock held low until the result exists.
// - Polling trigger: read header refused while no result exists.
// - No command except general-call reset accepted during the 45 ms triggered measurement.
// - Read gives pressure, temperature, scale words, each MSB first plus checksum.
// - Master may end a read with NACK and STOP; device lets go cleanly.
// - General call address 0x00 with byte 0x06 soft resets the device.
// - Soft reset is run by its own separate reset block.
// - For 2 ms after soft reset, address not acked and no command taken.
// - Sleep is entered only from idle.
// - A sleeping device ignores the general-call reset.
// - Own address with write bit wakes the sleeper into idle, not acked.
// - Device answers at seven-bit address 0x25.
// - Commands are two bytes; read words come with an eight-bit checksum.
// - Checksum is CRC-8, polynomial 0x31, start 0xFF, no reflection or final xor.
module smcc_core import smcc_pkg::*; #(
	parameter int MEAS_CYC        = SMCC_MEAS_CYC,
	parameter int RESET_CYC       = SMCC_RESET_CYC,
	parameter int CONT_FIRST_CYC  = SMCC_CONT_FIRST_CYC,
	parameter int CONT_PERIOD_CYC = SMCC_CONT_PERIOD_CYC
) (
	// System clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Link clock and bus pins
	input  wire logic        scl_link_clk,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             scl_out,
	output logic             scl_oe,
	output logic             sda_out,
	output logic             sda_oe,
	// Sensing path
	input  wire logic [15:0] pressure_difference_word,
	input  wire logic [15:0] temperature_word,
	input  wire logic [15:0] scale_factor_word,
	output logic             meas_start,
	output logic             heater_on,
	output logic             comp_mass_flow,
	output logic             soft_reset_busy
);

	// ==========================================================================
	// CRC-8 over one data word
	function automatic logic [7:0] smcc_crc8(input logic [15:0] data);
		logic [7:0] crc;
		crc = SMCC_CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			if (crc[7] ^ data[i]) begin
				crc = {crc[6:0], 1'b0} ^ SMCC_CRC_POLY;
			end else begin
				crc = {crc[6:0], 1'b0};
			end
		end
		return crc;
	endfunction

	// ==========================================================================
	// Link domain: data bit caught on the bus clock's own rising edge
	logic link_bit;

	always_ff @(posedge scl_link_clk) begin
		link_bit <= sda_in;
	end

	// ==========================================================================
	// Crossing into the system domain
	logic scl_s1, scl_s2, scl_s3;
	logic sda_s1, sda_s2, sda_s3;
	logic bit_s1, bit_s2;
	logic rise_d;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_s3 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_s3 <= 1'b1;
			bit_s1 <= 1'b0;
			bit_s2 <= 1'b0;
			rise_d <= 1'b0;
		end else begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
			bit_s1 <= link_bit;
			bit_s2 <= bit_s1;
			rise_d <= scl_s2 && !scl_s3;
		end
	end

	logic start_cond, stop_cond, scl_fall;

	assign start_cond = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
	assign stop_cond  = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
	assign scl_fall   = scl_s3 && !scl_s2;

	// ==========================================================================
	// State shared by the bus engine and the mode logic
	smcc_bus_t   bus_state, hdr_next;
	smcc_mode_t  mode;
	logic [3:0]  bit_cnt;
	logic [7:0]  shreg;
	logic        gc_mode;
	logic [1:0]  wr_cnt;
	logic [7:0]  cmd_hi;
	logic [15:0] cmd_word;
	logic        cmd_ev, gc_ev, wake_ev;
	logic [3:0]  rd_idx;
	logic        rel_pend, res_valid, trig_stretch;
	logic [15:0] res_p, res_t, res_s;
	smcc_cnt_t   meas_cnt, sr_cnt;

	// ==========================================================================
	// Read data selection
	logic [1:0]  tx_sel, tx_part;
	logic [15:0] tx_word;
	logic [7:0]  tx_byte;
	logic        tx_bit;

	always_comb begin
		tx_sel  = 2'(rd_idx / 4'd3);
		tx_part = 2'(rd_idx % 4'd3);
		tx_word = (tx_sel == 2'd0) ? res_p : (tx_sel == 2'd1) ? res_t : res_s;
		if (tx_part == 2'd0) begin
			tx_byte = tx_word[15:8];
		end else if (tx_part == 2'd1) begin
			tx_byte = tx_word[7:0];
		end else begin
			tx_byte = smcc_crc8(tx_word);
		end
		tx_bit = tx_byte[3'd7 - bit_cnt[2:0]];
	end

	// ==========================================================================
	// Bus target engine
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bus_state <= SMCC_BUS_IDLE;
			hdr_next  <= SMCC_BUS_SKIP;
			bit_cnt   <= 4'h0;
			shreg     <= 8'h00;
			gc_mode   <= 1'b0;
			wr_cnt    <= 2'h0;
			cmd_hi    <= 8'h00;
			cmd_word  <= 16'h0000;
			cmd_ev    <= 1'b0;
			gc_ev     <= 1'b0;
			wake_ev   <= 1'b0;
			rd_idx    <= 4'h0;
			rel_pend  <= 1'b0;
			scl_oe    <= 1'b0;
			sda_oe    <= 1'b0;
			scl_out   <= 1'b0;
			sda_out   <= 1'b0;
		end else begin
			cmd_ev  <= 1'b0;
			gc_ev   <= 1'b0;
			wake_ev <= 1'b0;
			if (start_cond) begin
				bus_state <= SMCC_BUS_ADDR;
				bit_cnt   <= 4'h0;
				sda_oe    <= 1'b0;
				rel_pend  <= 1'b0;
			end else if (stop_cond) begin
				bus_state <= SMCC_BUS_IDLE;
				sda_oe    <= 1'b0;
			end else if (rise_d) begin
				if (bit_cnt != SMCC_ACK_BIT) begin
					shreg   <= {shreg[6:0], bit_s2};
					bit_cnt <= bit_cnt + 4'h1;
				end else begin
					bit_cnt <= 4'h0;
					if (bus_state == SMCC_BUS_ADDR) begin
						bus_state <= hdr_next;
					end else if (bus_state == SMCC_BUS_READ) begin
						if (bit_s2) begin
							bus_state <= SMCC_BUS_SKIP;
						end else if (rd_idx == SMCC_LAST_BYTE) begin
							rd_idx <= 4'h0;
						end else begin
							rd_idx <= rd_idx + 4'h1;
						end
					end
				end
			end else if (scl_fall) begin
				if (bit_cnt == SMCC_ACK_BIT) begin
					sda_oe <= 1'b0;
					if (bus_state == SMCC_BUS_ADDR) begin
						hdr_next <= SMCC_BUS_SKIP;
						gc_mode  <= 1'b0;
						wr_cnt   <= 2'h0;
						if (soft_reset_busy) begin
							sda_oe <= 1'b0;
						end else if (mode == SMCC_MODE_SLEEP) begin
							// Wake address is seen but left unacknowledged
							wake_ev <= (shreg[7:1] == SMCC_OWN_ADDR) && !shreg[0];
						end else if (shreg[7:1] == SMCC_GC_ADDR && !shreg[0]) begin
							sda_oe   <= 1'b1;
							gc_mode  <= 1'b1;
							hdr_next <= SMCC_BUS_WRITE;
						end else if (shreg[7:1] == SMCC_OWN_ADDR) begin
							if (!shreg[0] && mode != SMCC_MODE_TRIG) begin
								sda_oe   <= 1'b1;
								hdr_next <= SMCC_BUS_WRITE;
							end else if (shreg[0] && (res_valid ||
									(mode == SMCC_MODE_TRIG && trig_stretch))) begin
								sda_oe   <= 1'b1;
								hdr_next <= SMCC_BUS_READ;
								rd_idx   <= 4'h0;
							end
						end
					end else if (bus_state == SMCC_BUS_WRITE) begin
						sda_oe <= 1'b1;
						if (gc_mode) begin
							gc_ev <= (shreg == SMCC_GC_RESET);
						end else if (wr_cnt == 2'h0) begin
							cmd_hi <= shreg;
						end else if (wr_cnt == 2'h1) begin
							cmd_word <= {cmd_hi, shreg};
							cmd_ev   <= 1'b1;
						end
						if (wr_cnt != SMCC_CMD_BYTES) begin
							wr_cnt <= wr_cnt + 2'h1;
						end
					end
				end else if (bus_state == SMCC_BUS_READ) begin
					if (!res_valid) begin
						scl_oe <= 1'b1;
					end else begin
						sda_oe <= !tx_bit;
					end
				end else begin
					sda_oe <= 1'b0;
				end
			end else if (scl_oe) begin
				// Data is set one cycle before the clock is let go
				if (rel_pend) begin
					scl_oe   <= 1'b0;
					rel_pend <= 1'b0;
				end else if (res_valid) begin
					sda_oe   <= !tx_bit;
					rel_pend <= 1'b1;
				end
			end
		end
	end

	// ==========================================================================
	// Separate soft reset block
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sr_cnt          <= '0;
			soft_reset_busy <= 1'b0;
		end else if (gc_ev && mode != SMCC_MODE_SLEEP) begin
			sr_cnt          <= smcc_cnt_t'(RESET_CYC);
			soft_reset_busy <= 1'b1;
		end else if (soft_reset_busy) begin
			sr_cnt <= sr_cnt - 1'b1;
			if (sr_cnt == smcc_cnt_t'(1)) begin
				soft_reset_busy <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// Measurement mode control
	always_ff @(posedge sys_clk) begin
		if (rst || soft_reset_busy) begin
			mode           <= SMCC_MODE_IDLE;
			meas_cnt       <= '0;
			meas_start     <= 1'b0;
			heater_on      <= 1'b0;
			comp_mass_flow <= 1'b0;
			trig_stretch   <= 1'b0;
			res_valid      <= 1'b0;
			res_p          <= 16'h0000;
			res_t          <= 16'h0000;
			res_s          <= 16'h0000;
		end else begin
			meas_start <= 1'b0;
			unique case (mode)
				SMCC_MODE_IDLE: begin
					if (cmd_ev) begin
						if (cmd_word == SMCC_CMD_TRIG_MF || cmd_word == SMCC_CMD_TRIG_DP ||
								cmd_word == SMCC_CMD_TRIG_MF_CS ||
								cmd_word == SMCC_CMD_TRIG_DP_CS) begin
							mode         <= SMCC_MODE_TRIG;
							meas_cnt     <= smcc_cnt_t'(MEAS_CYC);
							meas_start   <= 1'b1;
							heater_on    <= 1'b1;
							res_valid    <= 1'b0;
							trig_stretch <= cmd_word == SMCC_CMD_TRIG_MF_CS ||
								cmd_word == SMCC_CMD_TRIG_DP_CS;
							comp_mass_flow <= cmd_word == SMCC_CMD_TRIG_MF ||
								cmd_word == SMCC_CMD_TRIG_MF_CS;
						end else if (cmd_word == SMCC_CMD_CONT_MF_AV ||
								cmd_word == SMCC_CMD_CONT_MF ||
								cmd_word == SMCC_CMD_CONT_DP_AV ||
								cmd_word == SMCC_CMD_CONT_DP) begin
							mode           <= SMCC_MODE_CONT;
							meas_cnt       <= smcc_cnt_t'(CONT_FIRST_CYC);
							meas_start     <= 1'b1;
							heater_on      <= 1'b1;
							res_valid      <= 1'b0;
							trig_stretch   <= 1'b0;
							comp_mass_flow <= cmd_word == SMCC_CMD_CONT_MF_AV ||
								cmd_word == SMCC_CMD_CONT_MF;
						end else if (cmd_word == SMCC_CMD_SLEEP) begin
							mode <= SMCC_MODE_SLEEP;
						end
					end
				end
				SMCC_MODE_TRIG: begin
					meas_cnt <= meas_cnt - 1'b1;
					if (meas_cnt == smcc_cnt_t'(1)) begin
						mode      <= SMCC_MODE_IDLE;
						heater_on <= 1'b0;
						res_valid <= 1'b1;
						res_p     <= pressure_difference_word;
						res_t     <= temperature_word;
						res_s     <= scale_factor_word;
					end
				end
				SMCC_MODE_CONT: begin
					if (cmd_ev && cmd_word == SMCC_CMD_STOP) begin
						mode      <= SMCC_MODE_IDLE;
						heater_on <= 1'b0;
					end else begin
						// Other codes, new start codes included, are dropped
						meas_cnt <= meas_cnt - 1'b1;
						if (meas_cnt == smcc_cnt_t'(1)) begin
							meas_cnt   <= smcc_cnt_t'(CONT_PERIOD_CYC);
							meas_start <= 1'b1;
							res_valid  <= 1'b1;
							res_p      <= pressure_difference_word;
							res_t      <= temperature_word;
							res_s      <= scale_factor_word;
						end
					end
				end
				SMCC_MODE_SLEEP: begin
					if (wake_ev) begin
						mode <= SMCC_MODE_IDLE;
					end
				end
			endcase
		end
	end

endmodule

// ---- smcc_core_properties.sv ----
// Pin-level checks for the mode and command controller
module smcc_core_properties #(
	parameter int RESET_CYC = 80000
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Bus pins
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe,
	// Mode outputs
	input wire logic meas_start,
	input wire logic heater_on,
	input wire logic soft_reset_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	int busy_len;

	always_ff @(posedge sys_clk) begin
		if (rst || !soft_reset_busy) begin
			busy_len <= 0;
		end else begin
			busy_len <= busy_len + 1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_busy_held;
		soft_reset_busy ##1 soft_reset_busy;
	endsequence
	sequence s_stretch_done;
		scl_oe && !heater_on;
	endsequence

	// ==========================================================
	// Assertions
	a_start_heats: assert property (meas_start |-> ##[0:2] heater_on)
		else $error("measurement start without heater");
	a_start_pulse: assert property (meas_start |=> !meas_start)
		else $error("start pulse longer than one cycle");
	a_reset_length: assert property ($fell(soft_reset_busy) |-> busy_len == RESET_CYC)
		else $error("soft reset busy of wrong length");
	a_reset_quiet: assert property (s_busy_held |-> !heater_on && !meas_start)
		else $error("measurement active during soft reset");
	a_stretch_in_meas: assert property ($rose(scl_oe) |-> heater_on)
		else $error("clock stretch outside measurement");
	a_stretch_release: assert property (s_stretch_done |-> ##[0:4] !scl_oe)
		else $error("clock held after result ready");
	a_sda_steady: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data changed while clock high");
	a_pins_pull_low: assert property ((scl_oe || sda_oe) |-> !(scl_out || sda_out))
		else $error("pin driven high");
endmodule

bind smcc_core smcc_core_properties #(.RESET_CYC(RESET_CYC)) u_props (
	.sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_out(sda_out), .sda_oe(sda_oe), .meas_start(meas_start), .heater_on(heater_on),
	.soft_reset_busy(soft_reset_busy));

// ---- smcc_i2c_master.sv ----
// Two-wire bus master model for the controller's link pins
module smcc_i2c_master #(
	parameter int HALF_NS = 256
) (
	// Resolved bus lines
	input  wire logic scl,
	input  wire logic sda,
	// Open-drain pulls
	output logic      scl_low,
	output logic      sda_low
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	// Data moves only while the clock is low; waits while the device stretches
	task automatic bit_io(input logic b, output logic r);
		#50;
		sda_low = !b;
		#HALF_NS;
		scl_low = 1'b0;
		#1;
		for (int n = 0; n < 40000 && scl !== 1'b1; n++) #10;
		#HALF_NS;
		r = sda;
		scl_low = 1'b1;
	endtask

	task automatic start_c();
		sda_low = 1'b1;
		#HALF_NS;
		scl_low = 1'b1;
	endtask

	// Clock is left standing high after the frame
	task automatic stop_c();
		#50;
		sda_low = 1'b1;
		#HALF_NS;
		scl_low = 1'b0;
		#HALF_NS;
		sda_low = 1'b0;
		#HALF_NS;
	endtask

	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
		output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
		bit_io(ack_in, ack);
	endtask
endmodule

// ---- smcc_core_tb.sv ----
// Self-checking bench of the mode and command controller
module smcc_core_tb import smcc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MEAS = 2000;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        scl_oe, scl_out, sda_oe, sda_out, m_scl_low, m_sda_low;
	logic        meas_start, heater_on, comp_mass_flow, soft_reset_busy;
	logic [15:0] w_p = 16'hbeef;
	logic [15:0] w_t = 16'h1234;
	logic [15:0] w_s = 16'h003c;
	logic [7:0]  exp_b [9];
	int          failures = 0;
	int          compares = 0;
	int          starts = 0;
	wire         scl = !(m_scl_low || (scl_oe && !scl_out));
	wire         sda = !(m_sda_low || (sda_oe && !sda_out));

	always #12.5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) if (meas_start === 1'b1) starts++;

	smcc_core #(.MEAS_CYC(MEAS), .RESET_CYC(1000), .CONT_FIRST_CYC(100),
		.CONT_PERIOD_CYC(40)) DUT (
		.sys_clk(sys_clk), .rst(rst), .scl_link_clk(scl), .scl_in(scl), .sda_in(sda),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
		.pressure_difference_word(w_p), .temperature_word(w_t), .scale_factor_word(w_s),
		.meas_start(meas_start), .heater_on(heater_on), .comp_mass_flow(comp_mass_flow),
		.soft_reset_busy(soft_reset_busy));
	smcc_i2c_master m (.scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low));

	// ==========================================================
	// Helpers
	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = 8'hff;
		for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
		return c;
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic cmd(input logic [15:0] c);
		logic [7:0] r;
		logic       a0, a1, a2;
		m.start_c();
		m.xfer({SMCC_OWN_ADDR, 1'b0}, 1'b1, r, a0);
		m.xfer(c[15:8], 1'b1, r, a1);
		m.xfer(c[7:0], 1'b1, r, a2);
		m.stop_c();
		chk(16'({a0, a1, a2}), 16'h0);
	endtask

	task automatic probe(input logic [6:0] a, input logic rw, input logic exp_ack);
		logic [7:0] r;
		logic       ack;
		m.start_c();
		m.xfer({a, rw}, 1'b1, r, ack);
		m.stop_c();
		chk(16'(ack), 16'(exp_ack));
	endtask

	task automatic gc_reset(output logic ack);
		logic [7:0] r;
		logic       a;
		m.start_c();
		m.xfer({SMCC_GC_ADDR, 1'b0}, 1'b1, r, ack);
		m.xfer(8'h06, 1'b1, r, a);
		m.stop_c();
	endtask

	task automatic rd_result(input int n);
		logic [7:0] r;
		logic       ack;
		m.start_c();
		m.xfer({SMCC_OWN_ADDR, 1'b1}, 1'b1, r, ack);
		chk(16'(ack), 16'h0);
		for (int i = 0; i < n; i++) begin
			m.xfer(8'hff, i == n - 1, r, ack);
			chk(16'(r), 16'(exp_b[i]));
		end
		m.stop_c();
	endtask

	// ==========================================================
	// Scenarios
	task automatic test_poll();
		starts = 0;
		cmd(SMCC_CMD_TRIG_MF);
		chk(16'(heater_on), 16'h1);
		chk(16'(comp_mass_flow), 16'h1);
		probe(SMCC_OWN_ADDR, 1'b1, 1'b1);
		probe(SMCC_OWN_ADDR, 1'b0, 1'b1);
		for (int n = 0; n < 8000 && heater_on !== 1'b0; n++) @(posedge sys_clk);
		rd_result(9);
		chk(16'(starts), 16'h1);
		chk(16'(heater_on), 16'h0);
		$display("test poll done");
	endtask

	task automatic test_stretch();
		time t0;
		cmd(SMCC_CMD_TRIG_DP_CS);
		t0 = $time;
		chk(16'(comp_mass_flow), 16'h0);
		rd_result(3);
		chk(16'($time - t0 >= MEAS * 25), 16'h1);
		probe(SMCC_OWN_ADDR, 1'b0, 1'b0);
		$display("test stretch done");
	endtask

	task automatic test_cont();
		cmd(SMCC_CMD_CONT_DP);
		cmd(SMCC_CMD_TRIG_MF);
		chk(16'(comp_mass_flow), 16'h0);
		cmd(SMCC_CMD_SLEEP);
		probe(SMCC_OWN_ADDR, 1'b0, 1'b0);
		chk(16'(heater_on), 16'h1);
		cmd(SMCC_CMD_STOP);
		chk(16'(heater_on), 16'h0);
		cmd(SMCC_CMD_TRIG_MF);
		chk(16'(comp_mass_flow), 16'h1);
		for (int n = 0; n < 8000 && heater_on !== 1'b0; n++) @(posedge sys_clk);
		$display("test continuous done");
	endtask

	task automatic test_codes();
		cmd(SMCC_CMD_TRIG_DP);
		chk(16'({heater_on, comp_mass_flow}), 16'h2);
		for (int n = 0; n < 8000 && heater_on !== 1'b0; n++) @(posedge sys_clk);
		cmd(SMCC_CMD_TRIG_MF_CS);
		chk(16'({heater_on, comp_mass_flow}), 16'h3);
		rd_result(2);
		chk(16'(heater_on), 16'h0);
		cmd(SMCC_CMD_CONT_MF);
		chk(16'({heater_on, comp_mass_flow}), 16'h3);
		rd_result(3);
		cmd(SMCC_CMD_STOP);
		cmd(SMCC_CMD_CONT_DP_AV);
		chk(16'({heater_on, comp_mass_flow}), 16'h2);
		cmd(SMCC_CMD_STOP);
		cmd(SMCC_CMD_CONT_MF_AV);
		chk(16'({heater_on, comp_mass_flow}), 16'h3);
		cmd(SMCC_CMD_STOP);
		chk(16'(heater_on), 16'h0);
		$display("test codes done");
	endtask

	task automatic test_sleep();
		logic ack;
		cmd(SMCC_CMD_SLEEP);
		gc_reset(ack);
		chk(16'(ack), 16'h1);
		chk(16'(soft_reset_busy), 16'h0);
		probe(SMCC_OWN_ADDR, 1'b0, 1'b1);
		probe(SMCC_OWN_ADDR, 1'b0, 1'b0);
		$display("test sleep done");
	endtask

	task automatic test_reset();
		logic ack;
		cmd(SMCC_CMD_TRIG_MF);
		gc_reset(ack);
		chk(16'(ack), 16'h0);
		chk(16'(soft_reset_busy), 16'h1);
		chk(16'(heater_on), 16'h0);
		probe(SMCC_OWN_ADDR, 1'b0, 1'b1);
		for (int n = 0; n < 4000 && soft_reset_busy !== 1'b0; n++) @(posedge sys_clk);
		probe(SMCC_OWN_ADDR, 1'b0, 1'b0);
		$display("test reset done");
	endtask

	initial begin
		exp_b = '{w_p[15:8], w_p[7:0], crc8(w_p), w_t[15:8], w_t[7:0], crc8(w_t),
			w_s[15:8], w_s[7:0], crc8(w_s)};
		repeat (20) @(posedge sys_clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge sys_clk);
		test_poll();
		test_stretch();
		test_cont();
		test_codes();
		test_sleep();
		test_reset();
		give_verdict();
	end

	initial begin
		#2_000_000;
		failures++;
		give_verdict();
	end
endmodule
